//--- dpm_pkg.sv
// Shared constants, field layouts and enumerations of the dual-port converter input block.
package dpm_pkg;

    // ----------------------------------------------------------------
    // Data widths and code range
    // ----------------------------------------------------------------
    localparam int CODE_W = 14;                       // Straight binary code width, top bit is bit 13.
    localparam logic [CODE_W-1:0] CODE_MAX = 14'h3fff; // All-ones code, near full scale on the primary output.
    localparam logic [CODE_W-1:0] CODE_ZERO = 14'h0000; // Reset value of every data latch.

    // ----------------------------------------------------------------
    // Buffering and period measurement
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 32;                   // Words of buffering in front of the converter.
    localparam int PER_W = 16;                        // Width of the external clock period counter.
    localparam logic [PER_W-1:0] PER_ZERO = 16'h0000; // Counter restart value.
    localparam logic [PER_W-1:0] PER_ONE = 16'h0001;  // Counter step.
    localparam logic [PER_W-1:0] PER_MAX = 16'hffff;  // Saturation value, marks a stopped clock.

    // ----------------------------------------------------------------
    // Prescaler ratios presented while the multiplier is active
    // ----------------------------------------------------------------
    localparam logic [3:0] RANGE_SELECT_PIN_HIGH = 4'h1;
    localparam logic [3:0] RANGE_DIV2 = 4'h2;
    localparam logic [3:0] RANGE_DIV4 = 4'h4;
    localparam logic [3:0] RANGE_DIV8 = 4'h8;

    // Input mux modes, in the order of the {high, low} select pin code.
    typedef enum logic [1:0] {MODE_INTERLEAVE, MODE_PORT1, MODE_PORT2, MODE_INVALID} dpm_mode_t;

    // Phase of the doubled-rate transfer while the multiplier is active.
    typedef enum logic {PH_IDLE, PH_ARMED} dpm_phase_t;

    // The two input port latches travel together.
    typedef struct packed {
        logic [CODE_W-1:0] p1;
        logic [CODE_W-1:0] p2;
    } dpm_pair_t;

    // One converter word: complementary code above the primary code.
    typedef struct packed {
        logic [CODE_W-1:0] compl_code;
        logic [CODE_W-1:0] code;
    } dpm_word_t;

endpackage

//--- dpm_ram.sv
// Simple dual-port memory with a registered read port, used as FIFO storage.
`timescale 1ns/1ps
module dpm_ram #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32
) (
    // Clock.
    input wire logic clk,
    // Write side.
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read side.
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    // Storage array; contents are undefined until written.
    logic [WIDTH-1:0] mem [DEPTH];

    // Write and registered read share one clock; read data changes only on a read.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

//--- dpm_fifo.sv
// Parameterised FIFO with valid and ready on both sides and a registered output word.
`timescale 1ns/1ps
module dpm_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH); // Occupancy that refuses a push.
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

    logic [AW-1:0] wr_ptr_reg, wr_ptr_next; // Next slot to write.
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next; // Next slot to read.
    logic [AW:0] count_reg, count_next;     // Words held in the memory, output word excluded.
    logic valid_reg, valid_next;            // Output word is valid.
    logic push, rd_issue;

    // Full is honest: the memory refuses a push once every slot is taken.
    assign in_ready = (count_reg != CNT_FULL);
    assign push = in_valid && in_ready;
    // A read is issued only when the output slot is free in the next cycle.
    assign rd_issue = (count_reg != '0) && (!valid_reg || out_ready);
    assign out_valid = valid_reg;

    // Pointer, occupancy and output-valid next values.
    always_comb begin
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = rd_issue ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next = count_reg;
        if (push && !rd_issue) begin
            count_next = count_reg + CNT_ONE;
        end else if (!push && rd_issue) begin
            count_next = count_reg - CNT_ONE;
        end
        valid_next = rd_issue ? 1'b1 : (out_ready ? 1'b0 : valid_reg);
    end

    // State registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
            valid_reg <= valid_next;
        end
    end

    // Storage; its registered read port is the output word.
    dpm_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_ram (
        .clk(clk),
        .wr_en(push),
        .wr_addr(wr_ptr_reg),
        .wr_data(in_data),
        .rd_en(rd_issue),
        .rd_addr(rd_ptr_reg),
        .rd_data(out_data)
    );

endmodule

//--- dpm_top.sv
// Dual-port input latches, clock control and output latch feeding the converter word stream.
`timescale 1ns/1ps
// Operation
// - Multiplier on: both ports latch on rise.
// - Same rise moves old port two value out.
// - Half period later port one value moves out.
// - Transfer moments use measured period, not duty.
// - Supply pin low: multiplier off, full-rate clock.
// - Select pins choose interleave, port one, two.
// - Interleave off-mode divides clock by two internally.
// - Off mode: delayed slow clock on lock pin.
// - Reset pulse release forces slow clock high.
// - First edge drops slow clock, second loads.
// - Edges after release toggle the slow clock.
// - Single port: latch, then output next rise.
// - Code spans zero to all ones, complement too.
// - Multiplier on: reset input is ignored.
// - Multiplier on: lock pin shows loop lock.
// - Multiplier on: select pins give prescale ratio.
// - Port words are straight binary, bit 13 top.
module dpm_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Mode and clock control pins.
    input wire logic multiplier_supply_pin,
    input wire logic ext_clk,
    input wire logic align_reset,
    input wire logic select_pin_high,
    input wire logic select_pin_low,
    // Input data ports.
    input wire logic [dpm_pkg::CODE_W-1:0] port1_data,
    input wire logic [dpm_pkg::CODE_W-1:0] port2_data,
    // Converter word stream.
    input wire logic dac_ready,
    output logic dac_valid,
    output logic [dpm_pkg::CODE_W-1:0] dac_code,
    output logic [dpm_pkg::CODE_W-1:0] dac_code_compl,
    // Status.
    input wire logic overrun_clr,
    output logic lock_or_slow_clock_out,
    output logic [3:0] range_div,
    output logic invalid_sel,
    output logic overrun
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Complementary code: the share of full scale left to the second output.
    function automatic logic [dpm_pkg::CODE_W-1:0] compl_of(input logic [dpm_pkg::CODE_W-1:0] code);
        compl_of = dpm_pkg::CODE_MAX - code;
    endfunction

    // Prescaler ratio for a select pin code.
    function automatic logic [3:0] range_of(input dpm_pkg::dpm_mode_t sel);
        unique case (sel)
            dpm_pkg::MODE_INTERLEAVE: range_of = dpm_pkg::RANGE_SELECT_PIN_HIGH;
            dpm_pkg::MODE_PORT1: range_of = dpm_pkg::RANGE_DIV2;
            dpm_pkg::MODE_PORT2: range_of = dpm_pkg::RANGE_DIV4;
            dpm_pkg::MODE_INVALID: range_of = dpm_pkg::RANGE_DIV8;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Decoded pins
    // ----------------------------------------------------------------

    logic pll_on;                 // Multiplier powered, so active.
    dpm_pkg::dpm_mode_t sel_mode; // Select pins read as one code.
    logic ext_rise;               // Rising edge of the external clock seen this cycle.
    logic ext_q_reg;              // External clock one cycle back.

    assign pll_on = multiplier_supply_pin;
    assign sel_mode = dpm_pkg::dpm_mode_t'({select_pin_high, select_pin_low});
    assign ext_rise = ext_clk && !ext_q_reg;

    // ----------------------------------------------------------------
    // Clock tracking: period measure, half-period phase, slow clock
    // ----------------------------------------------------------------

    logic [dpm_pkg::PER_W-1:0] per_cnt_reg, per_cnt_next; // Cycles since the last rise.
    logic [dpm_pkg::PER_W-1:0] per_reg, per_next;         // Last measured period.
    logic [dpm_pkg::PER_W-1:0] cnt_plus;                  // Cycles counted including this one.
    dpm_pkg::dpm_phase_t phase_reg, phase_next;           // Waiting for the half-period transfer.
    logic locked_reg, locked_next;                        // Two equal periods seen in a row.
    logic slow_reg, slow_next;                            // Internal single-rate clock.
    logic first_xfer;                                     // Half-period transfer fires now.

    assign cnt_plus = (per_cnt_reg == dpm_pkg::PER_MAX) ? per_cnt_reg : per_cnt_reg + dpm_pkg::PER_ONE;
    // The half point comes from the measured period, so the duty cycle of the
    // external clock never moves it; the price is one period of learning.
    assign first_xfer = pll_on && !ext_rise && (phase_reg == dpm_pkg::PH_ARMED)
                        && (cnt_plus == (per_reg >> 1));

    // Next values of the clock tracking state.
    always_comb begin
        per_cnt_next = cnt_plus;
        per_next = per_reg;
        phase_next = phase_reg;
        locked_next = locked_reg;
        slow_next = slow_reg;
        if (ext_rise) begin
            // A rise restarts the count and stores the period just ended.
            per_cnt_next = dpm_pkg::PER_ZERO;
            per_next = cnt_plus;
            locked_next = (cnt_plus == per_reg) && (cnt_plus != dpm_pkg::PER_MAX);
        end else if (cnt_plus == dpm_pkg::PER_MAX) begin
            // A stopped clock drops lock.
            locked_next = 1'b0;
        end
        if (pll_on) begin
            // The rise wins over a late half-period transfer and re-arms it.
            if (ext_rise) begin
                phase_next = dpm_pkg::PH_ARMED;
            end else if (first_xfer) begin
                phase_next = dpm_pkg::PH_IDLE;
            end
            // Reset input has no effect here; the slow clock rests high.
            slow_next = 1'b1;
        end else begin
            phase_next = dpm_pkg::PH_IDLE;
            if (align_reset) begin
                // Released reset leaves the slow clock high.
                slow_next = 1'b1;
            end else if (ext_rise && sel_mode == dpm_pkg::MODE_INTERLEAVE) begin
                // Each double-rate edge toggles; an edge in the release cycle already counts.
                slow_next = !slow_reg;
            end
        end
    end

    // Clock tracking registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_q_reg <= 1'b0;
            per_cnt_reg <= dpm_pkg::PER_ZERO;
            per_reg <= dpm_pkg::PER_ZERO;
            phase_reg <= dpm_pkg::PH_IDLE;
            locked_reg <= 1'b0;
            slow_reg <= 1'b1;
        end else begin
            ext_q_reg <= ext_clk;
            per_cnt_reg <= per_cnt_next;
            per_reg <= per_next;
            phase_reg <= phase_next;
            locked_reg <= locked_next;
            slow_reg <= slow_next;
        end
    end

    // ----------------------------------------------------------------
    // Data path: input latches, output latch and buffer push
    // ----------------------------------------------------------------

    dpm_pkg::dpm_pair_t latch_reg, latch_next;               // Input port latches.
    logic [dpm_pkg::CODE_W-1:0] out_reg, out_next;           // Converter output latch.
    logic [dpm_pkg::CODE_W-1:0] push_code;                   // Value offered to the output latch.
    logic push_req;                                          // Output latch update wanted.
    logic push_fire;                                         // Update taken by the buffer.
    logic fifo_in_ready;                                     // Buffer has room.
    dpm_pkg::dpm_word_t push_word, fifo_out;
    logic slow_rise;                                         // Slow clock about to rise.

    assign slow_rise = !pll_on && !align_reset && ext_rise && !slow_reg;
    assign push_fire = push_req && fifo_in_ready;
    assign push_word.code = push_code;
    assign push_word.compl_code = compl_of(push_code);

    // Next values of the latches and the transfer request.
    always_comb begin
        latch_next = latch_reg;
        push_req = 1'b0;
        push_code = out_reg;
        if (pll_on) begin
            if (ext_rise) begin
                // Both ports latch together; the older port two word goes out.
                latch_next.p1 = port1_data;
                latch_next.p2 = port2_data;
                push_req = 1'b1;
                push_code = latch_reg.p2;
            end else if (first_xfer) begin
                push_req = 1'b1;
                push_code = latch_reg.p1;
            end
        end else begin
            unique case (sel_mode)
                dpm_pkg::MODE_INTERLEAVE: begin
                    if (slow_rise) begin
                        // The source changed data on this edge; latch both, port two out.
                        latch_next.p1 = port1_data;
                        latch_next.p2 = port2_data;
                        push_req = 1'b1;
                        push_code = latch_reg.p2;
                    end else if (ext_rise && !align_reset) begin
                        // Slow clock falling: port one goes out mid-cycle.
                        push_req = 1'b1;
                        push_code = latch_reg.p1;
                    end
                end
                dpm_pkg::MODE_PORT1: begin
                    if (ext_rise) begin
                        latch_next.p1 = port1_data;
                        push_req = 1'b1;
                        push_code = latch_reg.p1;
                    end
                end
                dpm_pkg::MODE_PORT2: begin
                    if (ext_rise) begin
                        latch_next.p2 = port2_data;
                        push_req = 1'b1;
                        push_code = latch_reg.p2;
                    end
                end
                dpm_pkg::MODE_INVALID: begin
                    // No port is chosen and the output latch holds.
                    push_req = 1'b0;
                end
            endcase
        end
        // A full buffer drops the offered word; the output latch keeps its old value.
        out_next = (push_req && fifo_in_ready) ? push_code : out_reg;
    end

    // Data path registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch_reg <= '{p1: dpm_pkg::CODE_ZERO, p2: dpm_pkg::CODE_ZERO};
            out_reg <= dpm_pkg::CODE_ZERO;
        end else begin
            latch_reg <= latch_next;
            out_reg <= out_next;
        end
    end

    // Buffer between the output latch and the converter word stream.
    dpm_fifo #(.WIDTH(2 * dpm_pkg::CODE_W), .DEPTH(dpm_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push_req),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(dac_valid),
        .out_ready(dac_ready),
        .out_data(fifo_out)
    );

    assign dac_code = fifo_out.code;
    assign dac_code_compl = fifo_out.compl_code;

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------

    logic lock_out_reg, lock_out_next;   // Lock pin.
    logic [3:0] range_reg, range_next;   // Prescaler ratio.
    logic invalid_reg, invalid_next;     // Forbidden select applied.
    logic overrun_reg, overrun_next;     // Transfer lost to a full buffer.

    // Next values of the status outputs.
    always_comb begin
        // With the multiplier off the lock pin is one cycle behind the slow clock, a delayed copy.
        lock_out_next = pll_on ? locked_reg : slow_reg;
        range_next = pll_on ? range_of(sel_mode) : dpm_pkg::RANGE_SELECT_PIN_HIGH;
        invalid_next = !pll_on && (sel_mode == dpm_pkg::MODE_INVALID);
        // A lost transfer in the clearing cycle still sets the flag.
        overrun_next = (push_req && !fifo_in_ready) || (overrun_reg && !overrun_clr);
    end

    // Status registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_out_reg <= 1'b0;
            range_reg <= dpm_pkg::RANGE_SELECT_PIN_HIGH;
            invalid_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            lock_out_reg <= lock_out_next;
            range_reg <= range_next;
            invalid_reg <= invalid_next;
            overrun_reg <= overrun_next;
        end
    end

    assign lock_or_slow_clock_out = lock_out_reg;
    assign range_div = range_reg;
    assign invalid_sel = invalid_reg;
    assign overrun = overrun_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Both ports are captured on an external rise.
    pll_capture_a: assert property (pll_on && ext_rise |=> latch_reg == $past({port1_data, port2_data}))
        else $error("ports not captured on external rise");
    // The old port two word reaches the output latch on the rise.
    pll_second_a: assert property (pll_on && ext_rise && fifo_in_ready |=> out_reg == $past(latch_reg.p2))
        else $error("port two word not transferred on rise");
    // The port one word follows at the half point.
    pll_half_a: assert property (first_xfer && fifo_in_ready |=> out_reg == $past(latch_reg.p1))
        else $error("port one word not transferred at half period");
    // Half-point transfer happens at half the measured period after the rise.
    half_timing_a: assert property (first_xfer |-> per_cnt_reg + dpm_pkg::PER_ONE == (per_reg >> 1))
        else $error("half transfer not at half the period");
    // Reset release leaves the slow clock high and the lock pin follows a cycle later.
    // An edge right after release may toggle it again, so only the forced value is checked.
    slow_reset_a: assert property (!pll_on && align_reset ##1 !pll_on
        |-> slow_reg ##1 lock_or_slow_clock_out)
        else $error("slow clock not forced high by reset");
    // Double-rate edges toggle the slow clock in interleaved mode.
    slow_toggle_a: assert property (!pll_on && !align_reset && ext_rise
        && sel_mode == dpm_pkg::MODE_INTERLEAVE |=> slow_reg != $past(slow_reg))
        else $error("slow clock did not toggle");
    // Port-one mode latches port one and outputs the older port one word.
    noninter_a: assert property (!pll_on && sel_mode == dpm_pkg::MODE_PORT1 && ext_rise && fifo_in_ready
        |=> latch_reg.p1 == $past(port1_data) && out_reg == $past(latch_reg.p1))
        else $error("single port transfer wrong");
    // The forbidden setting holds the output latch and raises the flag.
    invalid_hold_a: assert property (!pll_on && sel_mode == dpm_pkg::MODE_INVALID
        |=> $stable(out_reg) && invalid_sel)
        else $error("forbidden select not held");
    // Prescaler code 11 gives divide by eight.
    range_eight_a: assert property (pll_on && sel_mode == dpm_pkg::MODE_INVALID
        |=> range_div == dpm_pkg::RANGE_DIV8)
        else $error("prescale ratio wrong");
    // Every pushed word is a code and its exact complement.
    code_compl_a: assert property (push_fire |-> push_word.code + push_word.compl_code == dpm_pkg::CODE_MAX)
        else $error("complement code wrong");
    // Multiplier off: the lock pin is the slow clock one cycle late.
    lock_copy_a: assert property (!pll_on |=> lock_or_slow_clock_out == $past(slow_reg))
        else $error("lock pin does not follow the slow clock");
    // Multiplier on: the reset input cannot pull the slow clock away from its rest level.
    reset_ignored_a: assert property (pll_on |=> slow_reg)
        else $error("slow clock moved while multiplier on");

    interleave_c: cover property (!pll_on && slow_rise ##[1:20] (ext_rise && slow_reg));
    pll_lock_c: cover property (pll_on && locked_reg ##1 first_xfer);
    full_c: cover property (push_req && !fifo_in_ready);
    realign_c: cover property (!pll_on && align_reset ##1 !align_reset ##[1:12] ext_rise);

endmodule

//--- dpm_source.sv
// Data source model driving the converter clock and both data ports.
`timescale 1ns/1ps
module dpm_source (
    // Clock.
    input wire logic clk,
    // Control.
    input wire logic run,
    // Far-side outputs.
    output logic ext_clk,
    output logic [dpm_pkg::CODE_W-1:0] port1_data,
    output logic [dpm_pkg::CODE_W-1:0] port2_data
);
    logic [2:0] ph_reg = 3'h0; // Cycles into the half period.
    logic [12:0] cnt_reg = 13'h0000; // Pair counter.
    initial ext_clk = 1'b0;
    // Even code on port one, odd on port two, so a clean stream counts up.
    assign port1_data = {cnt_reg, 1'b0};
    assign port2_data = {cnt_reg, 1'b1};
    // The clock stands low while stopped; data moves on each rise.
    always @(posedge clk) begin
        if (run) begin
            ph_reg <= (ph_reg == 3'h4) ? 3'h0 : ph_reg + 3'h1;
            if (ph_reg == 3'h4) begin
                ext_clk <= !ext_clk;
                if (!ext_clk) begin
                    cnt_reg <= cnt_reg + 13'h0001;
                end
            end
        end else begin
            ext_clk <= 1'b0;
        end
    end
endmodule

//--- dpm_top_bench.sv
// Self-checking bench of the dual-port converter input block.
`timescale 1ns/1ps
module dpm_top_bench;
    logic clk = 1'b0, sys_rst = 1'b1, mult = 1'b1, align = 1'b0, hi = 1'b0, lo = 1'b0;
    logic ready = 1'b1, oclr = 1'b0, run = 1'b0, mon_on = 1'b0, have_prev = 1'b0;
    logic ext_clk, dac_valid, lock, inv, ovr;
    logic [13:0] p1, p2, code, compl, prev, step;
    logic [3:0] range;
    int failures = 0, check_count = 0, words = 0;
    // Rows: supply, sel high, sel low, prescale, invalid flag.
    logic [7:0] rows [8] = '{8'h82, 8'ha4, 8'hc8, 8'hf0, 8'h02, 8'h22, 8'h42, 8'h63};
    always #10 clk = !clk;
    dpm_source src (.clk(clk), .run(run), .ext_clk(ext_clk), .port1_data(p1), .port2_data(p2));
    dpm_top dut (.clk(clk), .sys_rst(sys_rst), .multiplier_supply_pin(mult), .ext_clk(ext_clk),
        .align_reset(align), .select_pin_high(hi), .select_pin_low(lo), .port1_data(p1),
        .port2_data(p2), .dac_ready(ready), .dac_valid(dac_valid), .dac_code(code),
        .dac_code_compl(compl), .overrun_clr(oclr), .lock_or_slow_clock_out(lock),
        .range_div(range), .invalid_sel(inv), .overrun(ovr));
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task conclude;
        if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Reset pulse of two cycles, then the reset values of every status output.
    task pulse_reset;
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        check("rst", {dac_valid, lock, range, inv, ovr}, 8'h04);
    endtask
    task wait_lock(input logic val);
        int n;
        for (n = 0; n < 14 && lock !== val; n++) tick(1);
        check("lock wait", {15'h0000, lock}, {15'h0000, val});
    endtask
    // Taken words must count up by the mode's step, complement alongside.
    // Sampled at the falling edge, where the word the next rise takes is settled.
    always @(negedge clk) begin
        if (mon_on && dac_valid && ready) begin
            check("compl", compl, 14'h3fff - code);
            if (have_prev) check("code", code, prev + step);
            prev = code;
            have_prev = 1'b1;
            words++;
        end
    end
    initial begin
        pulse_reset;
        for (int i = 0; i < 8; i++) begin
            {mult, hi, lo} <= rows[i][7:5];
            tick(3);
            check("range", range, rows[i][4:1]);
            check("invalid", inv, rows[i][0]);
        end
        // Interleave on multiplier, then port one and port two alone.
        for (int m = 0; m < 3; m++) begin
            {mult, hi, lo} <= (m == 0) ? 3'h4 : 3'(m);
            step = (m == 0) ? 14'h0001 : 14'h0002;
            run <= 1'b1;
            tick(30);
            {have_prev, words} = 0;
            mon_on <= 1'b1;
            tick(200);
            mon_on <= 1'b0;
            check("words", words > 17, 1'b1);
            if (m == 0) check("lock", lock, 1'b1);
        end
        {mult, hi, lo, run, align} <= 5'h01;
        tick(1);
        align <= 1'b0;
        tick(3);
        check("aligned", lock, 1'b1);
        run <= 1'b1;
        wait_lock(1'b0);
        // Realign while the slow clock is low, well away from the next edge.
        align <= 1'b1;
        tick(1);
        align <= 1'b0;
        tick(2);
        check("realigned", lock, 1'b1);
        wait_lock(1'b0);
        wait_lock(1'b1);
        {mult, ready} <= 2'h2;
        tick(400);
        run <= 1'b0;
        // Long enough for a pending half-period transfer to fall before the clear.
        tick(12);
        check("overrun", {ovr, dac_valid}, 2'h3);
        oclr <= 1'b1;
        tick(1);
        {oclr, ready} <= 2'h1;
        tick(80);
        check("drained", {ovr, dac_valid}, 2'h0);
        pulse_reset;
        conclude;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        conclude;
    end
endmodule
